// [rtl/amo_alarm_mask_offset_regs.sv]
// Alarm mask, lane FIFO alarm and offset trim register bank behind an APB slave.
//
// Functional notes
// (RL1) Alarm mask resets to 0x3F.
// (RL2) Mask bit 5 gates FIFO alarm.
// (RL3) Mask bit 4 gates serdes lock alarm.
// (RL4) Mask bit 3 gates link alarm.
// (RL5) Mask bit 2 gates realign alarm.
// (RL6) Mask bit 0 gates divider alarm.
// (RL7) Software keeps reserved mask bits default.
// (RL8) Lane FIFO fault sets its lane flag.
// (RL9) Lane flags reset to 0xFF.
// (RL10) Writing one clears a lane flag.
// (RL11) Persisting fault sets flag again immediately.
// (RL12) Clearing FIFO summary clears all lanes.
// (RL13) Offset is 12 bits, upper bits zero.
// (RL14) Offsets default from fuse memory.
// (RL15) Second offset drives core one.
// (RL16) Third offset applies only on input A.
// (RL17) No offset access during offset calibration.
// (RL18) Wait for foreground done when required.
// (RL19) Never access offsets in background tracking.
// (RL20) Background without tracking: offset tracking off.
// (RL21) Foreground step still trims spare cores.
// (RL22) Otherwise offsets are freely accessible.
// (RL23) Alarm status bits reset to one.
// (RL24) Link disabled leaves non-clock alarms undefined.
// (RL25) Summary is OR of unmasked alarms.
`timescale 1ns/10ps

module amo_alarm_mask_offset_regs
(
  input  wire logic                             clk_sys,
  input  wire logic                             resetn,
  input  wire logic                             softReset,
  input  wire logic [amo_pkg::AMO_ADDR_W-1:0]   paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [amo_pkg::AMO_DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [amo_pkg::AMO_DATA_W-1:0]   prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [amo_pkg::AMO_LANES-1:0]    laneFifoError,
  input  wire logic                             serdesLockLost,
  input  wire logic                             linkStateError,
  input  wire logic                             realignEvent,
  input  wire logic                             dividerMismatch,
  input  wire logic                             serialLinkEnable,
  input  wire logic                             fuseReady,
  input  wire logic [amo_pkg::AMO_OFS_W-1:0]    fuseOffset0,
  input  wire logic [amo_pkg::AMO_OFS_W-1:0]    fuseOffset1,
  input  wire logic [amo_pkg::AMO_OFS_W-1:0]    fuseOffset2a,
  input  wire logic                             core2SampleInputA,
  output logic      [amo_pkg::AMO_OFS_W-1:0]    core0OffsetTrim,
  output logic      [amo_pkg::AMO_OFS_W-1:0]    core1OffsetTrim,
  output logic      [amo_pkg::AMO_OFS_W-1:0]    core2OffsetTrim,
  output logic                                  offsetsLoaded,
  output logic                                  summaryAlarm
);
  import amo_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0]           alarmMask_reg;
  logic [7:0]           alarmStatus_reg;
  logic [7:0]           alarmStatus_next;
  logic [7:0]           alarmEvents;
  logic [7:0]           statusClear;
  logic [AMO_LANES-1:0] laneFlags_reg;
  logic [AMO_LANES-1:0] laneFlags_next;
  logic [AMO_LANES-1:0] laneClear;
  logic [AMO_OFS_W-1:0] ofsCore0_reg;
  logic [AMO_OFS_W-1:0] ofsCore1_reg;
  logic [AMO_OFS_W-1:0] ofsCore2a_reg;
  logic [AMO_OFS_W-1:0] core2Applied_reg;
  logic [AMO_DATA_W-1:0] readData_reg;
  logic                 summary_reg;
  amo_fuse_state_t      fuseState_reg;
  logic                 setupPhase;
  logic                 writeTaken;
  logic                 clearAllLanes;
  logic                 addrMapped;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // True when the byte address selects the register with the given index.
  function automatic logic hitsIndex(input logic [AMO_ADDR_W-1:0] addr,
                                     input logic [AMO_IDX_W-1:0]  idx);
    hitsIndex = (addr == {idx, 2'b00});
  endfunction

  // The slave never stalls, so every access phase completes in one cycle.
  assign pready     = 1'b1;
  assign setupPhase = psel && !penable;
  assign writeTaken = psel && penable && pwrite && pready;
  assign addrMapped = hitsIndex(paddr, AMO_IDX_ALARM_STATUS) ||
                      hitsIndex(paddr, AMO_IDX_ALARM_MASK)   ||
                      hitsIndex(paddr, AMO_IDX_LANE_FLAGS)   ||
                      hitsIndex(paddr, AMO_IDX_OFS_CORE0)    ||
                      hitsIndex(paddr, AMO_IDX_OFS_CORE1)    ||
                      hitsIndex(paddr, AMO_IDX_OFS_CORE2A);

  // Unmapped addresses answer with an error and change nothing.
  assign pslverr = psel && penable && !addrMapped;

  // ---------------------------------------------------------------------------
  // Alarm mask register
  // ---------------------------------------------------------------------------
  // Reserved bits are stored as written; software is trusted to keep them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alarmMask_reg <= AMO_MASK_RESET;                          // see RL1
    end else if (softReset) begin
      alarmMask_reg <= AMO_MASK_RESET;
    end else if (writeTaken && pstrb[0] && hitsIndex(paddr, AMO_IDX_ALARM_MASK)) begin
      alarmMask_reg <= pwdata[7:0];                             // see RL7
    end
  end

  // ---------------------------------------------------------------------------
  // Alarm status register (write one to clear)
  // ---------------------------------------------------------------------------
  // Link side alarms are only raised while the link runs, since they carry
  // no meaning otherwise; the FIFO and divider alarms are always live.
  always_comb begin
    alarmEvents                  = 8'h00;
    alarmEvents[AMO_BIT_FIFO]    = |laneFifoError;
    alarmEvents[AMO_BIT_SERDES]  = serdesLockLost && serialLinkEnable;   // see RL24
    alarmEvents[AMO_BIT_LINK]    = linkStateError && serialLinkEnable;
    alarmEvents[AMO_BIT_REALIGN] = realignEvent && serialLinkEnable;
    alarmEvents[AMO_BIT_DIVIDER] = dividerMismatch;
  end

  assign statusClear   = (writeTaken && pstrb[0] && hitsIndex(paddr, AMO_IDX_ALARM_STATUS)) ?
                         pwdata[7:0] : 8'h00;
  assign clearAllLanes = statusClear[AMO_BIT_FIFO];               // see RL12

  // A new event in the clearing cycle wins over the clear.
  assign alarmStatus_next = (alarmStatus_reg & ~statusClear) | alarmEvents;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alarmStatus_reg <= AMO_STATUS_RESET;                      // see RL23
    end else if (softReset) begin
      alarmStatus_reg <= AMO_STATUS_RESET;
    end else begin
      alarmStatus_reg <= alarmStatus_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Lane FIFO alarm flags
  // ---------------------------------------------------------------------------
  // Each lane clears on its own written one or on the summary clear, and a
  // fault still present in that cycle keeps the flag set.
  for (genvar lane = 0; lane < AMO_LANES; lane++) begin : g_lane
    assign laneClear[lane] = clearAllLanes ||
                             (writeTaken && pstrb[0] && pwdata[lane] &&
                              hitsIndex(paddr, AMO_IDX_LANE_FLAGS));       // see RL10
    assign laneFlags_next[lane] = (laneFlags_reg[lane] && !laneClear[lane]) ||
                                  laneFifoError[lane];                      // see RL8
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      laneFlags_reg <= AMO_LANE_RESET;                          // see RL9
    end else if (softReset) begin
      laneFlags_reg <= AMO_LANE_RESET;
    end else begin
      laneFlags_reg <= laneFlags_next;                          // see RL11
    end
  end

  // ---------------------------------------------------------------------------
  // Summary alarm
  // ---------------------------------------------------------------------------
  // Registered so the output never glitches; it trails the status by a cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      summary_reg <= 1'b0;
    end else if (softReset) begin
      summary_reg <= 1'b0;
    end else begin
      summary_reg <= |(alarmStatus_reg & ~alarmMask_reg & AMO_ALARM_SOURCES); // see RL25
    end
  end

  assign summaryAlarm = summary_reg;                            // see RL2 RL3 RL4 RL5 RL6

  // ---------------------------------------------------------------------------
  // Offset trims and fuse loading
  // ---------------------------------------------------------------------------
  // The trims start from fuse memory once it reports valid; writes before
  // that are dropped so a late fuse load cannot overwrite software values.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fuseState_reg <= AMO_FUSE_WAIT;
    end else if (softReset) begin
      fuseState_reg <= AMO_FUSE_WAIT;
    end else begin
      unique case (fuseState_reg)
        AMO_FUSE_WAIT: begin
          if (fuseReady) begin
            fuseState_reg <= AMO_FUSE_DONE;
          end
        end
        AMO_FUSE_DONE: fuseState_reg <= AMO_FUSE_DONE;
      endcase
    end
  end

  // Offset registers keep twelve bits; the twenty reserved upper bits are not stored.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ofsCore0_reg  <= AMO_OFS_RESET;
      ofsCore1_reg  <= AMO_OFS_RESET;
      ofsCore2a_reg <= AMO_OFS_RESET;
    end else if (softReset) begin
      ofsCore0_reg  <= AMO_OFS_RESET;
      ofsCore1_reg  <= AMO_OFS_RESET;
      ofsCore2a_reg <= AMO_OFS_RESET;
    end else if (fuseState_reg == AMO_FUSE_WAIT) begin
      if (fuseReady) begin
        ofsCore0_reg  <= fuseOffset0;                           // see RL14
        ofsCore1_reg  <= fuseOffset1;
        ofsCore2a_reg <= fuseOffset2a;
      end
    end else if (writeTaken && pstrb[0] && pstrb[1]) begin
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE0)) begin
        ofsCore0_reg <= pwdata[AMO_OFS_W-1:0];                  // see RL13
      end
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE1)) begin
        ofsCore1_reg <= pwdata[AMO_OFS_W-1:0];                  // see RL15
      end
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE2A)) begin
        ofsCore2a_reg <= pwdata[AMO_OFS_W-1:0];
      end
    end
  end

  // Core two gets this trim only while it samples the first input pair; the
  // other pair's trim lives elsewhere, so zero is passed meanwhile.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core2Applied_reg <= AMO_OFS_RESET;
    end else begin
      core2Applied_reg <= core2SampleInputA ? ofsCore2a_reg : AMO_OFS_RESET; // see RL16
    end
  end

  assign core0OffsetTrim = ofsCore0_reg;
  assign core1OffsetTrim = ofsCore1_reg;                        // see RL15
  assign core2OffsetTrim = core2Applied_reg;
  assign offsetsLoaded   = (fuseState_reg == AMO_FUSE_DONE);

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // Read data is captured in the setup cycle so it stands from a flip-flop
  // for the whole access phase; unused bits read as zero.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      readData_reg <= '0;
    end else if (setupPhase && !pwrite) begin
      readData_reg <= '0;
      if (hitsIndex(paddr, AMO_IDX_ALARM_STATUS)) begin
        readData_reg[7:0] <= alarmStatus_reg;
      end
      if (hitsIndex(paddr, AMO_IDX_ALARM_MASK)) begin
        readData_reg[7:0] <= alarmMask_reg;
      end
      if (hitsIndex(paddr, AMO_IDX_LANE_FLAGS)) begin
        readData_reg[7:0] <= laneFlags_reg;
      end
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE0)) begin
        readData_reg[AMO_OFS_W-1:0] <= ofsCore0_reg;            // see RL13
      end
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE1)) begin
        readData_reg[AMO_OFS_W-1:0] <= ofsCore1_reg;
      end
      if (hitsIndex(paddr, AMO_IDX_OFS_CORE2A)) begin
        readData_reg[AMO_OFS_W-1:0] <= ofsCore2a_reg;
      end
    end
  end

  assign prdata = readData_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_mask_reset_val: assert property ($rose(resetn) |-> alarmMask_reg == 8'h3F) // see RL1
    else $error("Alarm mask did not come out of reset as 0x3F.");

  a_lane_reset_val: assert property ($rose(resetn) |-> laneFlags_reg == 8'hFF) // see RL9
    else $error("Lane flags did not come out of reset as 0xFF.");

  a_status_reset_val: assert property ($rose(resetn) |-> alarmStatus_reg == 8'h3F) // see RL23
    else $error("Alarm status did not come out of reset all ones.");

  a_lane_fault_sets: assert property ((laneFifoError != 8'h00) && !softReset |=>
      ((laneFlags_reg & $past(laneFifoError)) == $past(laneFifoError))) // see RL8
    else $error("A lane fault did not set its lane flag.");

  a_lane_w1c_clear: assert property (writeTaken && pstrb[0] && !softReset &&
      hitsIndex(paddr, AMO_IDX_LANE_FLAGS) && laneFifoError == 8'h00 && !clearAllLanes |=>
      laneFlags_reg == ($past(laneFlags_reg) & ~$past(pwdata[7:0]))) // see RL10
    else $error("Lane flag write did not clear exactly the written ones.");

  a_lane_refault_set: assert property ((laneClear & laneFifoError) != 8'h00 && !softReset |=>
      (laneFlags_reg & $past(laneClear) & $past(laneFifoError)) ==
      ($past(laneClear) & $past(laneFifoError))) // see RL11
    else $error("A persisting lane fault was lost by a clear.");

  a_lane_clear_all: assert property (clearAllLanes && laneFifoError == 8'h00 &&
      !softReset |=> laneFlags_reg == 8'h00) // see RL12
    else $error("Summary FIFO clear left lane flags set.");

  a_summary_or: assert property (!softReset ##1 !softReset |->
      summaryAlarm == |($past(alarmStatus_reg) & ~$past(alarmMask_reg) & 8'h3D)) // see RL25
    else $error("Summary alarm does not match the unmasked alarms.");

  a_fifo_masked: assert property (alarmMask_reg[AMO_BIT_FIFO] && !softReset |=>
      summaryAlarm == |($past(alarmStatus_reg) & ~$past(alarmMask_reg) & 8'h1D)) // see RL2
    else $error("Masked FIFO alarm reached the summary.");

  a_serdes_gate: assert property (alarmStatus_reg == 8'h10 && !alarmMask_reg[4] &&
      !softReset |=> summaryAlarm) // see RL3
    else $error("Unmasked serdes lock alarm missed the summary.");

  a_link_gate: assert property (alarmStatus_reg == 8'h08 && alarmMask_reg[3] &&
      !softReset |=> !summaryAlarm) // see RL4
    else $error("Masked link alarm reached the summary.");

  a_realign_gate: assert property (alarmStatus_reg == 8'h04 && alarmMask_reg[2] &&
      !softReset |=> !summaryAlarm) // see RL5
    else $error("Masked realign alarm reached the summary.");

  a_divider_gate: assert property (alarmStatus_reg == 8'h01 && !alarmMask_reg[0] &&
      !softReset |=> summaryAlarm) // see RL6
    else $error("Unmasked divider alarm missed the summary.");

  a_ofs_read_top: assert property (setupPhase && !pwrite &&
      hitsIndex(paddr, AMO_IDX_OFS_CORE1) |=> prdata[31:12] == 20'h00000 &&
      prdata[11:0] == $past(ofsCore1_reg)) // see RL13
    else $error("Offset read returned wrong data or nonzero upper bits.");

  a_fuse_load: assert property (fuseState_reg == AMO_FUSE_WAIT && fuseReady &&
      !softReset |=> core0OffsetTrim == $past(fuseOffset0) &&
      core1OffsetTrim == $past(fuseOffset1) && offsetsLoaded) // see RL14
    else $error("Offset trims did not load from fuse memory.");

  a_core2_gate: assert property (!core2SampleInputA |=> core2OffsetTrim == 12'h000) // see RL16
    else $error("Core two trim applied outside the first input pair.");

  c_lane_clear: cover property (laneClear != 8'h00 ##1 laneFlags_reg != 8'hFF);
  c_clear_all: cover property (clearAllLanes ##1 laneFlags_reg == 8'h00);
  c_summary_rise: cover property (!summaryAlarm ##1 summaryAlarm);
  c_offset_write: cover property (writeTaken && hitsIndex(paddr, AMO_IDX_OFS_CORE2A) &&
      offsetsLoaded);

endmodule

// [rtl/amo_pkg.sv]
// Constants, field positions and reset values for the alarm mask and offset trim registers.
package amo_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned AMO_ADDR_W  = 12;
  localparam int unsigned AMO_DATA_W  = 32;
  localparam int unsigned AMO_IDX_W   = 10;
  localparam int unsigned AMO_LANES   = 8;
  localparam int unsigned AMO_OFS_W   = 12;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_ALARM_STATUS = 10'h2C0;
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_ALARM_MASK   = 10'h2C2;
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_LANE_FLAGS   = 10'h2C4;
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_OFS_CORE0    = 10'h330;
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_OFS_CORE1    = 10'h332;
  localparam logic [AMO_IDX_W-1:0] AMO_IDX_OFS_CORE2A   = 10'h334;

  // ---------------------------------------------------------------------------
  // Alarm bit positions, shared by the status and the mask registers
  // ---------------------------------------------------------------------------
  localparam int unsigned AMO_BIT_FIFO    = 5;
  localparam int unsigned AMO_BIT_SERDES  = 4;
  localparam int unsigned AMO_BIT_LINK    = 3;
  localparam int unsigned AMO_BIT_REALIGN = 2;
  localparam int unsigned AMO_BIT_DIVIDER = 0;

  // Alarm sources that can reach the summary output.
  localparam logic [7:0] AMO_ALARM_SOURCES = 8'h3D;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]           AMO_MASK_RESET   = 8'h3F;
  localparam logic [7:0]           AMO_STATUS_RESET = 8'h3F;
  localparam logic [7:0]           AMO_LANE_RESET   = 8'hFF;
  localparam logic [AMO_OFS_W-1:0] AMO_OFS_RESET    = 12'h000;

  // Offset trim loading from fuse memory.
  typedef enum logic [0:0] {
    AMO_FUSE_WAIT,
    AMO_FUSE_DONE
  } amo_fuse_state_t;

endpackage

// [testbench/tb.sv]
// Self-checking testbench for the alarm mask, lane alarm and offset trim register bank.
`timescale 1ns/10ps

module tb;
  import amo_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals, addresses and the table of ordinary register cases
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_STAT = {AMO_IDX_ALARM_STATUS, 2'b00};
  localparam logic [11:0] ADDR_MASK = {AMO_IDX_ALARM_MASK, 2'b00};
  localparam logic [11:0] ADDR_LANE = {AMO_IDX_LANE_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_TRIM0 = {AMO_IDX_OFS_CORE0, 2'b00};
  localparam logic [11:0] ADDR_TRIM1 = {AMO_IDX_OFS_CORE1, 2'b00};
  localparam logic [11:0] ADDR_TRIM2 = {AMO_IDX_OFS_CORE2A, 2'b00};
  typedef struct {logic [11:0] addr; logic [31:0] wdata; logic [31:0] exp; logic err;} amo_row_t;
  amo_row_t rows [6] = '{'{ADDR_MASK, 32'h0000_0012, 32'h0000_0012, 1'b0},
                         '{ADDR_TRIM0, 32'hFFFF_FABC, 32'h0000_0ABC, 1'b0},
                         '{ADDR_TRIM1, 32'h0000_0123, 32'h0000_0123, 1'b0},
                         '{ADDR_TRIM2, 32'h0000_0FFF, 32'h0000_0FFF, 1'b0},
                         '{12'hB04,   32'h0000_00FF, 32'h0000_0000, 1'b1},
                         '{ADDR_MASK, 32'h0000_003F, 32'h0000_003F, 1'b0}};
  int          srcBits [5] = '{5, 4, 3, 2, 0};
  logic        clk_sys   = 1'b0;
  logic        resetn    = 1'b0;
  logic        softReset = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [7:0]  laneErr   = 8'h00;
  logic [5:0]  evt       = 6'h00;
  logic        linkEn    = 1'b1;
  logic        sampleA   = 1'b1;
  logic        fuseRdy   = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [11:0] trim0, trim1, trim2;
  logic        pready, pslverr, offsetsLoaded, summaryAlarm, err;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;

  amo_alarm_mask_offset_regs amo_alarm_mask_offset_regs_inst (
    .clk_sys(clk_sys), .resetn(resetn), .softReset(softReset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .laneFifoError(laneErr | {7'h00, evt[5]}), .serdesLockLost(evt[4]),
    .linkStateError(evt[3]), .realignEvent(evt[2]), .dividerMismatch(evt[0]),
    .serialLinkEnable(linkEn), .fuseReady(fuseRdy), .fuseOffset0(12'h5A5),
    .fuseOffset1(12'h1C3), .fuseOffset2a(12'h2E7), .core2SampleInputA(sampleA),
    .core0OffsetTrim(trim0), .core1OffsetTrim(trim1), .core2OffsetTrim(trim2),
    .offsetsLoaded(offsetsLoaded), .summaryAlarm(summaryAlarm));

  // ---------------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ---------------------------------------------------------------------------
  // The clock toggles every half period of the 50 MHz system clock.
  always #10 clk_sys = ~clk_sys;

  // A stuck handshake would otherwise hang the run forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test;
    end
  end

  task finish_test;
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // One APB transfer; the idle edge first keeps psel from being driven twice in one step.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A one-cycle alarm event on the source whose mask bit is b.
  task pulse(input int b);
    @(posedge clk_sys);
    evt[b] <= 1'b1;
    @(posedge clk_sys);
    evt <= 6'h00;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  // Reset values and fuse loading first, then the table, then the awkward cases by hand.
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    apb(0, ADDR_MASK, 0); chk("mask reset", 32'h3F, rd);
    apb(0, ADDR_LANE, 0); chk("lane reset", 32'hFF, rd);
    apb(0, ADDR_STAT, 0); chk("status reset", 32'h3F, rd);
    chk("not loaded", 32'h0, {31'h0, offsetsLoaded});
    apb(1, ADDR_TRIM0, 32'h123);
    fuseRdy <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("loaded", 32'h1, {31'h0, offsetsLoaded});
    apb(0, ADDR_TRIM0, 0); chk("fuse offset", 32'h5A5, rd);
    chk("fuse trim", 32'h1C3, {20'h0, trim1});
    foreach (rows[i]) begin
      apb(1, rows[i].addr, rows[i].wdata);
      chk("write error", {31'h0, rows[i].err}, {31'h0, err});
      apb(0, rows[i].addr, 0);
      chk("read data", rows[i].exp, rd);
      chk("read error", {31'h0, rows[i].err}, {31'h0, err});
    end
    repeat (2) @(posedge clk_sys);
    chk("core0 trim", 32'hABC, {20'h0, trim0});
    chk("core1 trim", 32'h123, {20'h0, trim1});
    chk("core2 trim", 32'hFFF, {20'h0, trim2});
    sampleA <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("core2 idle", 32'h0, {20'h0, trim2});
    apb(1, ADDR_LANE, 32'h0F); apb(0, ADDR_LANE, 0); chk("lane clear", 32'hF0, rd);
    laneErr <= 8'h40;
    apb(1, ADDR_LANE, 32'hF0); apb(0, ADDR_LANE, 0); chk("lane persist", 32'h40, rd);
    laneErr <= 8'h00;
    apb(1, ADDR_STAT, 32'h20); apb(0, ADDR_LANE, 0); chk("lane all", 32'h00, rd);
    laneErr <= 8'h04;
    @(posedge clk_sys);
    laneErr <= 8'h00;
    apb(0, ADDR_LANE, 0); chk("lane set", 32'h04, rd);
    foreach (srcBits[i]) begin
      apb(1, ADDR_MASK, 32'h3F);
      apb(1, ADDR_STAT, 32'h3F);
      pulse(srcBits[i]);
      repeat (2) @(posedge clk_sys);
      chk("summary masked", 32'h0, {31'h0, summaryAlarm});
      apb(1, ADDR_MASK, 32'h3F & ~(32'h1 << srcBits[i]));
      repeat (2) @(posedge clk_sys);
      chk("summary open", 32'h1, {31'h0, summaryAlarm});
    end
    apb(1, ADDR_STAT, 32'h3F);
    repeat (2) @(posedge clk_sys);
    chk("summary cleared", 32'h0, {31'h0, summaryAlarm});
    linkEn <= 1'b0;
    pulse(3);
    pulse(0);
    apb(0, ADDR_STAT, 0); chk("link off", 32'h01, rd);
    linkEn <= 1'b1;
    @(posedge clk_sys);
    softReset <= 1'b1;
    @(posedge clk_sys);
    softReset <= 1'b0;
    apb(0, ADDR_MASK, 0); chk("soft mask", 32'h3F, rd);
    apb(0, ADDR_LANE, 0); chk("soft lane", 32'hFF, rd);
    apb(0, ADDR_STAT, 0); chk("soft status", 32'h3F, rd);
    chk("soft trim", 32'h5A5, {20'h0, trim0});
    finish_test;
  end
endmodule
